//--- logic/gpio_cfg.svh
// constants of the three-port general i/o block: offsets, widths, resets
// assumes inclusion by bare name from the package and the testbench
//
// Operation
// - each port pin has a software read/write data latch; reset leaves latches alone
// - serial port six bits; timer and analog ports eight bits each
// - direction bit 1 enables output buffer; 0 makes the pin an input
// - reset clears every direction bit, so all pins start as inputs
// - serial port data read returns latch where direction bit is 1
// - timer port data read returns latch where direction bit is 1
// - analog port data read returns latch where direction bit is 1
// - where direction bit is 0, data read returns the sampled pin level
// - data writes always update latches and never alter input readback
// - serial unit owns its pins' direction; direction still selects read source
// - serial enable set makes bit 1 receive input, bit 0 transmit output
// - timer port upper four pins follow each channel's edge/level select
// - selected analog channel overrides port logic, forcing that pin to input
// - unselected analog port pins behave as ordinary digital i/o
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SERIAL_DATA_OFS 16'h0008
`define TIMER_DATA_OFS 16'h0440
`define ANALOG_DATA_OFS 16'h0441
`define SERIAL_DIR_OFS 16'h0442
`define TIMER_DIR_OFS 16'h0443
`define ANALOG_DIR_OFS 16'h0444
`define SHARE_CTRL_OFS 16'h0445
`define ANALOG_SEL_OFS 16'h0446

// ----------------------------------------------------------------------
// widths and field positions
// ----------------------------------------------------------------------
`define SERIAL_WIDTH 6
`define WIDE_WIDTH 8
`define SERIAL_RX_BIT 1
`define SERIAL_TX_BIT 0
`define TIMER_CH_LSB 4
`define CTRL_SERIAL_EN_BIT 0
`define CTRL_ANALOG_EN_BIT 1
`define CTRL_TIMER_LSB 4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DIR_RESET 8'h00
`define CTRL_RESET 8'h00
`define SEL_RESET 3'h0

`endif

//--- logic/gpio_pkg.sv
// types shared by the general i/o modules
// assumes gpio_cfg.svh on the include path
package gpio_pkg;
  `include "gpio_cfg.svh"
  typedef logic [15:0] addr_t;
  typedef logic [7:0] byte_t;
  // ----------------------------------------------------------------------
  // access kind of the registered read
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_READ = 2'b01,
    ACC_WRITE = 2'b10
  } access_e;
endpackage

//--- logic/gpio_port_bank.sv
// one port: data latch, direction bits, pin drive and read mux
// assumes synchronous pin inputs and a one-cycle write strobe
`timescale 1ns/1ps
module gpio_port_bank #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic data_we,
  input wire logic dir_we,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] periph_own,
  input wire logic [WIDTH-1:0] periph_out,
  input wire logic [WIDTH-1:0] periph_drive,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe_n,
  output logic [WIDTH-1:0] data_view,
  output logic [WIDTH-1:0] dir_view
);
  import gpio_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] dir;
  } bank_s;

  // power-up value only; reset itself never touches the latch
  bank_s state_reg = '0;
  bank_s state_next;

  always_comb begin
    state_next = state_reg;
    if (data_we) begin
      state_next.latch = wdata;
    end
    if (dir_we) begin
      state_next.dir = wdata;
    end
    if (!rst_n) begin
      state_next.dir = '0;
    end
  end

  // latch keeps its value through reset on purpose
  always_ff @(posedge sys_clk) begin
    state_reg <= state_next;
  end

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (periph_own[i]) begin
        pin_out[i] = periph_out[i];
        pin_oe_n[i] = !periph_drive[i];
      end else begin
        pin_out[i] = state_reg.latch[i];
        pin_oe_n[i] = !state_reg.dir[i];
      end
      // direction picks the read source even for owned pins
      data_view[i] = state_reg.dir[i] ? state_reg.latch[i] : pin_in[i];
    end
  end

  assign dir_view = state_reg.dir;

  a_dir_reset: assert property (@(posedge sys_clk)
    !rst_n |=> state_reg.dir == '0)
    else $error("direction not cleared by reset");
  a_latch_keep: assert property (@(posedge sys_clk)
    (!rst_n && !data_we) |=> state_reg.latch == $past(state_reg.latch))
    else $error("latch disturbed by reset");
  a_write_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    data_we |=> state_reg.latch == $past(wdata))
    else $error("latch write lost");
  a_oe_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !periph_own[0] |-> pin_oe_n[0] == !state_reg.dir[0])
    else $error("output enable not from direction");
  a_read_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !dir_view[0] |-> data_view[0] == pin_in[0])
    else $error("input read not from pin");
endmodule

//--- logic/three_port_general_io.sv
// general i/o for the serial, timer and analog shared ports
// assumes synchronous pins and a single-cycle register master
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module three_port_general_io (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire gpio_pkg::addr_t addr,
  input wire gpio_pkg::byte_t wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output gpio_pkg::byte_t rdata,
  input wire logic [5:0] serial_pin_in,
  output logic [5:0] serial_pin_out,
  output logic [5:0] serial_pin_oe_n,
  input wire logic [7:0] timer_pin_in,
  output logic [7:0] timer_pin_out,
  output logic [7:0] timer_pin_oe_n,
  input wire logic [7:0] analog_pin_in,
  output logic [7:0] analog_pin_out,
  output logic [7:0] analog_pin_oe_n,
  input wire logic serial_tx_data,
  output logic serial_rx_data,
  input wire logic [3:0] timer_ch_out,
  input wire logic [3:0] timer_ch_drive,
  output logic [3:0] timer_ch_in,
  output logic serial_unit_enable,
  output logic analog_sel_valid,
  output logic [2:0] analog_channel,
  output logic [3:0] channel_edge_level_select
);
  import gpio_pkg::*;

  localparam int SW = `SERIAL_WIDTH;
  localparam int WW = `WIDE_WIDTH;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    byte_t ctrl;
    logic [2:0] sel;
    byte_t rdata;
  } top_s;

  top_s state_reg;
  top_s state_next;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  logic hit_sd, hit_td, hit_ad, hit_sr, hit_tr, hit_ar;
  assign hit_sd = wr_stb && addr == `SERIAL_DATA_OFS;
  assign hit_td = wr_stb && addr == `TIMER_DATA_OFS;
  assign hit_ad = wr_stb && addr == `ANALOG_DATA_OFS;
  assign hit_sr = wr_stb && addr == `SERIAL_DIR_OFS;
  assign hit_tr = wr_stb && addr == `TIMER_DIR_OFS;
  assign hit_ar = wr_stb && addr == `ANALOG_DIR_OFS;

  // ----------------------------------------------------------------------
  // sharing control
  // ----------------------------------------------------------------------
  logic [SW-1:0] s_own, s_out, s_drv;
  logic [WW-1:0] t_own, t_out, t_drv, a_own;
  logic [3:0] els;

  assign serial_unit_enable = state_reg.ctrl[`CTRL_SERIAL_EN_BIT];
  assign analog_sel_valid = state_reg.ctrl[`CTRL_ANALOG_EN_BIT];
  assign analog_channel = state_reg.sel;
  assign els = state_reg.ctrl[`CTRL_TIMER_LSB +: 4];
  assign channel_edge_level_select = els;

  always_comb begin
    s_own = '0;
    s_out = '0;
    s_drv = '0;
    if (serial_unit_enable) begin
      s_own[`SERIAL_RX_BIT] = 1'b1;
      s_own[`SERIAL_TX_BIT] = 1'b1;
      s_out[`SERIAL_TX_BIT] = serial_tx_data;
      s_drv[`SERIAL_TX_BIT] = 1'b1;
    end
    t_own = {els, 4'h0};
    t_out = {timer_ch_out, 4'h0};
    t_drv = {timer_ch_drive, 4'h0};
    a_own = '0;
    if (analog_sel_valid) begin
      a_own[state_reg.sel] = 1'b1;
    end
  end

  // receive line idles high while the serial unit is off
  assign serial_rx_data = serial_unit_enable ?
    serial_pin_in[`SERIAL_RX_BIT] : 1'b1;
  assign timer_ch_in = timer_pin_in[`TIMER_CH_LSB +: 4];

  // ----------------------------------------------------------------------
  // port banks
  // ----------------------------------------------------------------------
  logic [SW-1:0] s_view, s_dir;
  logic [WW-1:0] t_view, t_dir, a_view, a_dir;

  gpio_port_bank #(.WIDTH(SW)) u_serial (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .data_we(hit_sd),
    .dir_we(hit_sr),
    .wdata(wdata[SW-1:0]),
    .pin_in(serial_pin_in),
    .periph_own(s_own),
    .periph_out(s_out),
    .periph_drive(s_drv),
    .pin_out(serial_pin_out),
    .pin_oe_n(serial_pin_oe_n),
    .data_view(s_view),
    .dir_view(s_dir)
  );

  gpio_port_bank #(.WIDTH(WW)) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .data_we(hit_td),
    .dir_we(hit_tr),
    .wdata(wdata),
    .pin_in(timer_pin_in),
    .periph_own(t_own),
    .periph_out(t_out),
    .periph_drive(t_drv),
    .pin_out(timer_pin_out),
    .pin_oe_n(timer_pin_oe_n),
    .data_view(t_view),
    .dir_view(t_dir)
  );

  // unselected analog pins get no override: plain digital i/o
  gpio_port_bank #(.WIDTH(WW)) u_analog (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .data_we(hit_ad),
    .dir_we(hit_ar),
    .wdata(wdata),
    .pin_in(analog_pin_in),
    .periph_own(a_own),
    .periph_out('0),
    .periph_drive('0),
    .pin_out(analog_pin_out),
    .pin_oe_n(analog_pin_oe_n),
    .data_view(a_view),
    .dir_view(a_dir)
  );

  // ----------------------------------------------------------------------
  // register file and read mux
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rdata = 8'h00;
    if (wr_stb && addr == `SHARE_CTRL_OFS) begin
      state_next.ctrl = wdata;
    end
    if (wr_stb && addr == `ANALOG_SEL_OFS) begin
      state_next.sel = wdata[2:0];
    end
    if (rd_stb) begin
      case (addr)
        `SERIAL_DATA_OFS: state_next.rdata = {2'b00, s_view};
        `TIMER_DATA_OFS: state_next.rdata = t_view;
        `ANALOG_DATA_OFS: state_next.rdata = a_view;
        `SERIAL_DIR_OFS: state_next.rdata = {2'b00, s_dir};
        `TIMER_DIR_OFS: state_next.rdata = t_dir;
        `ANALOG_DIR_OFS: state_next.rdata = a_dir;
        `SHARE_CTRL_OFS: state_next.rdata = state_reg.ctrl;
        `ANALOG_SEL_OFS: state_next.rdata = {5'b0_0000, state_reg.sel};
        default: state_next.rdata = 8'h00;
      endcase
    end
    if (!rst_n) begin
      state_next.ctrl = `CTRL_RESET;
      state_next.sel = `SEL_RESET;
      state_next.rdata = 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    state_reg <= state_next;
  end

  assign rdata = state_reg.rdata;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_serial_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rd_stb && addr == `SERIAL_DATA_OFS && s_dir[2]) |=>
    rdata[2] == $past(s_view[2]))
    else $error("serial port read wrong");
  a_timer_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rd_stb && addr == `TIMER_DATA_OFS) |=> rdata == $past(t_view))
    else $error("timer port read wrong");
  a_analog_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rd_stb && addr == `ANALOG_DATA_OFS) |=> rdata == $past(a_view))
    else $error("analog port read wrong");
  a_serial_tx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    serial_unit_enable |-> (serial_pin_out[0] == serial_tx_data &&
    !serial_pin_oe_n[0] && serial_pin_oe_n[1]))
    else $error("serial pins not taken over");
  a_analog_force: assert property (@(posedge sys_clk) disable iff (!rst_n)
    analog_sel_valid |-> analog_pin_oe_n[analog_channel])
    else $error("analog pin still driven");
  a_write_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (hit_td && t_dir[0]) |=> timer_pin_out[0] == $past(wdata[0]))
    else $error("write not at pin next edge");
  a_timer_own: assert property (@(posedge sys_clk) disable iff (!rst_n)
    els[0] |-> timer_pin_oe_n[4] == !timer_ch_drive[0])
    else $error("timer channel not steering pin");

  c_serial_on: cover property (@(posedge sys_clk) $rose(serial_unit_enable));
  c_analog_on: cover property (@(posedge sys_clk) $rose(analog_sel_valid));
  c_read_wr: cover property (@(posedge sys_clk) wr_stb ##1 rd_stb);
endmodule

//--- verif/pin_world.sv
// board side of one port: the pin shows its driver or the outside level
// assumes active-low output enables and no pull device on the pins
`timescale 1ns/1ps
module pin_world #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pout,
  input wire logic [W-1:0] poen_n,
  input wire logic [W-1:0] ext,
  output logic [W-1:0] pin
);
  // ----------------------------------------------------------------------
  // pin level
  // ----------------------------------------------------------------------
  // released pins float, so the bench keeps varying the outside level
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin[i] = poen_n[i] ? ext[i] : pout[i];
    end
  end
endmodule

//--- verif/three_port_general_io_tb.sv
// self-checking bench for the three-port general i/o block
// assumes the design files and pin_world compile first
`timescale 1ns/1ps
`include "gpio_cfg.svh"
module three_port_general_io_tb;
  import gpio_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  addr_t addr = 16'h0000;
  byte_t wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic rd_seen = 1'b0;
  logic tx = 1'b0;
  logic [3:0] ch_out = 4'h0;
  logic [3:0] ch_drv = 4'h0;
  byte_t ext [3] = '{8'h00, 8'h00, 8'h00};
  byte_t lat [3];
  byte_t dir [3];
  byte_t msk [3] = '{8'h3f, 8'hff, 8'hff};
  addr_t dofs [3] = '{`SERIAL_DATA_OFS, `TIMER_DATA_OFS, `ANALOG_DATA_OFS};
  addr_t rofs [3] = '{`SERIAL_DIR_OFS, `TIMER_DIR_OFS, `ANALOG_DIR_OFS};
  byte_t exp_q [$];
  byte_t rdata;
  logic [5:0] s_in, s_out, s_oe_n;
  wire [7:0] pout [3];
  wire [7:0] poen [3];
  wire [7:0] t_in, g_in;
  logic rx, s_en, a_val;
  logic [2:0] a_ch;
  logic [3:0] ch_in, els;
  int seed, num_errors, checks, cyc;

  assign pout[0] = {2'b00, s_out};
  assign poen[0] = {2'b00, s_oe_n};

  three_port_general_io uut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .serial_pin_in(s_in), .serial_pin_out(s_out), .serial_pin_oe_n(s_oe_n),
    .timer_pin_in(t_in), .timer_pin_out(pout[1]), .timer_pin_oe_n(poen[1]),
    .analog_pin_in(g_in), .analog_pin_out(pout[2]),
    .analog_pin_oe_n(poen[2]), .serial_tx_data(tx), .serial_rx_data(rx),
    .timer_ch_out(ch_out), .timer_ch_drive(ch_drv), .timer_ch_in(ch_in),
    .serial_unit_enable(s_en), .analog_sel_valid(a_val),
    .analog_channel(a_ch), .channel_edge_level_select(els));
  pin_world #(.W(6)) s_world (.pout(s_out), .poen_n(s_oe_n),
    .ext(ext[0][5:0]), .pin(s_in));
  pin_world t_world (.pout(pout[1]), .poen_n(poen[1]), .ext(ext[1]),
    .pin(t_in));
  pin_world g_world (.pout(pout[2]), .poen_n(poen[2]), .ext(ext[2]),
    .pin(g_in));

  always #50 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------------
  // bus tasks: entered just after an edge, return just after the next
  // ----------------------------------------------------------------------
  task automatic wr(input addr_t a, input byte_t d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input addr_t a, input byte_t e);
    exp_q.push_back(e);
    addr <= a;
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
  endtask

  task automatic idle();
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------------
  // compares and verdict
  // ----------------------------------------------------------------------
  task automatic report(input byte_t got, input byte_t exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_read(input byte_t got, input byte_t exp);
    report(got, exp);
  endtask

  task automatic cmp_pin(input byte_t got, input byte_t exp);
    report(got, exp);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk) rd_seen <= rd_stb;
  always @(negedge sys_clk) begin
    if (rd_seen) cmp_read(rdata, exp_q.pop_front());
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    seed = 32'h8702;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (int p = 0; p < 3; p++) cmp_pin(poen[p], msk[p]);
    for (int p = 0; p < 3; p++) rd(rofs[p], 8'h00);
    rd(`SHARE_CTRL_OFS, 8'h00);
    rd(16'h0447, 8'h00);
    $display("test reset values done");
    repeat (4) begin
      for (int p = 0; p < 3; p++) begin
        lat[p] = byte_t'($random(seed));
        dir[p] = byte_t'($random(seed)) & msk[p];
        ext[p] <= byte_t'($random(seed));
        wr(dofs[p], lat[p]);
        wr(rofs[p], dir[p]);
        rd(dofs[p], ((dir[p] & lat[p]) | (~dir[p] & ext[p])) & msk[p]);
        rd(rofs[p], dir[p]);
        cmp_pin(poen[p], ~dir[p] & msk[p]);
        cmp_pin(pout[p] & dir[p], lat[p] & dir[p]);
      end
    end
    $display("test latch and direction done");
    rst_n <= 1'b0;
    idle();
    rst_n <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      rd(rofs[p], 8'h00);
      wr(rofs[p], msk[p]);
      rd(dofs[p], lat[p] & msk[p]);
    end
    $display("test reset keeps latches done");
    ext[0] <= 8'h28;
    tx <= 1'b1;
    wr(`SHARE_CTRL_OFS, 8'h01);
    wr(rofs[0], 8'h00);
    rd(dofs[0], 8'h29);
    cmp_pin({7'h00, rx}, 8'h00);
    cmp_pin({7'h00, s_en}, 8'h01);
    wr(rofs[0], 8'h3f);
    idle();
    cmp_pin(poen[0], 8'h02);
    $display("test serial sharing done");
    ext[1] <= 8'hc0;
    ch_drv <= 4'h5;
    ch_out <= 4'h3;
    wr(`SHARE_CTRL_OFS, 8'hf0);
    wr(rofs[1], 8'h00);
    rd(dofs[1], 8'h90);
    cmp_pin(poen[1], 8'haf);
    cmp_pin({ch_in, els}, 8'h9f);
    $display("test timer sharing done");
    wr(rofs[2], 8'hff);
    wr(`SHARE_CTRL_OFS, 8'h02);
    wr(`ANALOG_SEL_OFS, 8'h03);
    idle();
    cmp_pin(poen[2], 8'h08);
    cmp_pin({a_val, 4'h0, a_ch}, 8'h83);
    idle();
    $display("test analog sharing done");
    tally_and_finish();
  end
endmodule
